/* verilog/resolver_pkg.sv */
package resolver_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_PRI_MODE = 8'h00;
  localparam logic [7:0] OFS_SEC_MODE = 8'h04;
  localparam logic [7:0] OFS_NOMINAL = 8'h08;
  localparam logic [7:0] OFS_DEADBAND = 8'h0C;
  localparam logic [7:0] OFS_PRI_LOW_LIMIT = 8'h10;
  localparam logic [7:0] OFS_SEC_LOW_LIMIT = 8'h14;
  localparam logic [7:0] OFS_PRI_ERROR = 8'h18;
  localparam logic [7:0] OFS_SEC_ERROR = 8'h1C;
  localparam logic [7:0] OFS_DRIVE = 8'h20;
  localparam logic [7:0] OFS_CHECK_INTERVAL = 8'h24;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h28;
  localparam logic [7:0] OFS_PENDING = 8'h2C;
  localparam logic [7:0] OFS_PRI_POSITION = 8'h30;
  localparam logic [7:0] OFS_SEC_POSITION = 8'h34;
  localparam logic [7:0] OFS_AMPLITUDES = 8'h38;

  // field positions
  localparam int RESOLVER_EVENT_BIT = 7;
  localparam int MODE_W = 9;
  localparam int AMP_W = 16;
  localparam int DRIVE_W = 16;
  localparam int POS_W = 16;
  localparam int LOW_RES_SHIFT = 3;

  // reset values
  localparam logic [MODE_W-1:0] MODE_RESET = 9'h000;
  localparam logic [AMP_W-1:0] NOMINAL_RESET = 16'h3A98;
  localparam logic [AMP_W-1:0] DEADBAND_RESET = 16'h0064;
  localparam logic [AMP_W-1:0] LOW_LIMIT_RESET = 16'h0000;
  localparam logic [DRIVE_W-1:0] DRIVE_RESET = 16'h8000;
  localparam logic [31:0] CHECK_INTERVAL_RESET = 32'h0000_03E8;
  localparam logic [7:0] MASK_RESET = 8'h00;

  // drive adjustment limits
  localparam logic [DRIVE_W-1:0] DRIVE_MIN = 16'h0000;
  localparam logic [DRIVE_W-1:0] DRIVE_MAX = 16'hFFFF;
  localparam logic [DRIVE_W-1:0] DRIVE_STEP = 16'h0001;

  // reason codes
  localparam logic [7:0] REASON_NONE = 8'h00;
  localparam logic [7:0] REASON_LOW_AMPLITUDE = 8'h01;
  localparam logic [7:0] REASON_DRIVE_AT_MAX = 8'h02;
  localparam logic [7:0] REASON_DRIVE_AT_MIN = 8'h03;

  // mode word: 256, 128 ccw, 64, 32 compensation, 16 high resolution, low bits base mode
  typedef struct packed {
    logic spare8;
    logic ccw;
    logic spare6;
    logic compensate;
    logic high_res;
    logic [3:0] base;
  } channel_mode_s;

  typedef struct packed {
    logic [AMP_W-1:0] amplitude;
    logic [AMP_W-1:0] low_limit;
  } amp_check_s;

endpackage

/* verilog/position_scaler.sv */
`timescale 1ns/1ps
module position_scaler
  import resolver_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input channel_mode_s mode,
  input wire logic [POS_W-1:0] angle,
  output logic [POS_W-1:0] position
);

  logic [POS_W-1:0] next_position;
  logic [POS_W-1:0] coarse;

  always_comb
  begin
    coarse = angle >> LOW_RES_SHIFT;
    if (mode.high_res)
    begin
      // 65536 increments per turn, full angle word
      next_position = mode.ccw ? POS_W'(-angle) : angle;
    end
    else
    begin
      // one eighth of the increments in low resolution
      next_position = mode.ccw ? POS_W'(-coarse) : coarse;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      position <= '0;
    else if (mode.base != 4'h0)
      position <= next_position;
  end

endmodule

/* verilog/resolver_mode_supervision.sv */
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
// Function
// - mode 16 gives 65536 increments per turn
// - each channel picks high resolution independently
// - primary high resolution enables secondary supervision
// - inactive secondary channel is never checked
// - secondary channel is supervised, never compensated
// - secondary below low limit raises error
// - supervision starts only when mode bit set
// - mode 32 samples amplitude every interval
// - compensation steers drive toward nominal amplitude
// - drive unchanged inside the deadband
// - low amplitude or drive limit raises error
// - mode bit 7 selects ccw positive
// - interrupt delivered only with mask bit 7
// - pending bit 7 flags the error event
// - larger drive gives smaller excitation
module resolver_mode_supervision
  import resolver_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_RSTN,
  input wire logic [7:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [AMP_W-1:0] I_PRI_AMPLITUDE,
  input wire logic [AMP_W-1:0] I_SEC_AMPLITUDE,
  input wire logic [POS_W-1:0] I_PRI_ANGLE,
  input wire logic [POS_W-1:0] I_SEC_ANGLE,
  output logic [31:0] O_RDATA,
  output logic [DRIVE_W-1:0] O_EXCITATION_DRIVE,
  output logic O_RESOLVER_IRQ,
  output logic [POS_W-1:0] O_PRI_POSITION,
  output logic [POS_W-1:0] O_SEC_POSITION
);

  logic rst_meta_n;
  logic rst_n;

  channel_mode_s primary_channel_mode;
  channel_mode_s secondary_channel_mode;
  logic [AMP_W-1:0] nominal_amplitude_target;
  logic [AMP_W-1:0] amplitude_deadband;
  logic [AMP_W-1:0] primary_amplitude_low_limit;
  logic [AMP_W-1:0] secondary_amplitude_low_limit;
  logic [7:0] primary_error_reason;
  logic [7:0] secondary_error_reason;
  logic [DRIVE_W-1:0] excitation_drive_setting;
  logic [31:0] amplitude_check_interval;
  logic [7:0] system_interrupt_mask;
  logic system_pending_event;

  logic [31:0] interval_count;
  logic check_tick;
  logic compensating;
  logic secondary_supervised;
  logic timer_running;

  amp_check_s pri_check;
  amp_check_s sec_check;
  logic pri_low;
  logic sec_low;
  logic amp_above;
  logic [AMP_W-1:0] amp_error;
  logic outside_band;
  logic drive_up;
  logic drive_down;
  logic drive_at_max;
  logic drive_at_min;
  logic pri_fault;
  logic [7:0] pri_reason;
  logic sec_fault;
  logic event_set;
  logic pending_clear;
  logic [31:0] next_rdata;

  channel_mode_s chan_mode [2];
  logic [POS_W-1:0] chan_angle [2];
  logic [POS_W-1:0] chan_position [2];

  // async assert, release through two flops
  always_ff @(posedge I_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  // mode decode: each weight is its own flag, so options add up
  assign compensating = primary_channel_mode.compensate;
  assign secondary_supervised = primary_channel_mode.high_res && (secondary_channel_mode.base != 4'h0);
  assign timer_running = compensating || secondary_supervised;

  // interval timer, held in reset until a supervising mode bit is set
  always_ff @(posedge I_CLK or negedge rst_n)
  begin
    if (!rst_n)
      interval_count <= '0;
    else if (!timer_running || check_tick)
      interval_count <= '0;
    else
      interval_count <= interval_count + 32'h0000_0001;
  end

  // an interval of zero checks every cycle
  assign check_tick = timer_running && (interval_count >= amplitude_check_interval);

  assign pri_check = '{amplitude: I_PRI_AMPLITUDE, low_limit: primary_amplitude_low_limit};
  assign sec_check = '{amplitude: I_SEC_AMPLITUDE, low_limit: secondary_amplitude_low_limit};
  assign pri_low = pri_check.amplitude < pri_check.low_limit;
  assign sec_low = sec_check.amplitude < sec_check.low_limit;

  always_comb
  begin
    amp_above = pri_check.amplitude > nominal_amplitude_target;
    amp_error = amp_above ? AMP_W'(pri_check.amplitude - nominal_amplitude_target)
                          : AMP_W'(nominal_amplitude_target - pri_check.amplitude);
    outside_band = amp_error > amplitude_deadband;
    drive_at_max = excitation_drive_setting == DRIVE_MAX;
    drive_at_min = excitation_drive_setting == DRIVE_MIN;
    // excitation falls as drive rises: too much amplitude means raise drive
    drive_up = outside_band && amp_above && !drive_at_max && !pri_low;
    drive_down = outside_band && !amp_above && !drive_at_min && !pri_low;
    pri_fault = 1'b0;
    pri_reason = REASON_NONE;
    if (pri_low)
    begin
      pri_fault = 1'b1;
      pri_reason = REASON_LOW_AMPLITUDE;
    end
    else if (outside_band && amp_above && drive_at_max)
    begin
      pri_fault = 1'b1;
      pri_reason = REASON_DRIVE_AT_MAX;
    end
    else if (outside_band && !amp_above && drive_at_min)
    begin
      pri_fault = 1'b1;
      pri_reason = REASON_DRIVE_AT_MIN;
    end
  end

  assign sec_fault = secondary_supervised && sec_low;

  assign event_set = check_tick && ((compensating && pri_fault) || sec_fault);
  assign pending_clear = I_WR && (I_ADDR == OFS_PENDING) && I_WDATA[RESOLVER_EVENT_BIT];

  // mode and limit registers
  always_ff @(posedge I_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      primary_channel_mode <= MODE_RESET;
      secondary_channel_mode <= MODE_RESET;
      nominal_amplitude_target <= NOMINAL_RESET;
      amplitude_deadband <= DEADBAND_RESET;
      primary_amplitude_low_limit <= LOW_LIMIT_RESET;
      secondary_amplitude_low_limit <= LOW_LIMIT_RESET;
      amplitude_check_interval <= CHECK_INTERVAL_RESET;
      system_interrupt_mask <= MASK_RESET;
    end
    else if (I_WR)
    begin
      unique case (I_ADDR)
        OFS_PRI_MODE: primary_channel_mode <= I_WDATA[MODE_W-1:0];
        OFS_SEC_MODE: secondary_channel_mode <= I_WDATA[MODE_W-1:0];
        OFS_NOMINAL: nominal_amplitude_target <= I_WDATA[AMP_W-1:0];
        OFS_DEADBAND: amplitude_deadband <= I_WDATA[AMP_W-1:0];
        OFS_PRI_LOW_LIMIT: primary_amplitude_low_limit <= I_WDATA[AMP_W-1:0];
        OFS_SEC_LOW_LIMIT: secondary_amplitude_low_limit <= I_WDATA[AMP_W-1:0];
        OFS_CHECK_INTERVAL: amplitude_check_interval <= I_WDATA;
        OFS_IRQ_MASK: system_interrupt_mask <= I_WDATA[7:0];
        default: ;
      endcase
    end
  end

  // excitation drive: only the primary channel steers it, secondary is never compensated
  always_ff @(posedge I_CLK or negedge rst_n)
  begin
    if (!rst_n)
      excitation_drive_setting <= DRIVE_RESET;
    else if (compensating && check_tick && drive_up)
      excitation_drive_setting <= excitation_drive_setting + DRIVE_STEP;
    else if (compensating && check_tick && drive_down)
      excitation_drive_setting <= excitation_drive_setting - DRIVE_STEP;
    else if (I_WR && I_ADDR == OFS_DRIVE)
      // a software write loses to a same-cycle step; software should stay off while compensating
      excitation_drive_setting <= I_WDATA[DRIVE_W-1:0];
  end

  // reason codes keep the last error
  always_ff @(posedge I_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      primary_error_reason <= REASON_NONE;
      secondary_error_reason <= REASON_NONE;
    end
    else
    begin
      if (check_tick && compensating && pri_fault)
        primary_error_reason <= pri_reason;
      if (check_tick && sec_fault)
        secondary_error_reason <= REASON_LOW_AMPLITUDE;
    end
  end

  // pending event: a new error beats a clear in the same cycle
  always_ff @(posedge I_CLK or negedge rst_n)
  begin
    if (!rst_n)
      system_pending_event <= 1'b0;
    else if (event_set)
      system_pending_event <= 1'b1;
    else if (pending_clear)
      system_pending_event <= 1'b0;
  end

  always_ff @(posedge I_CLK or negedge rst_n)
  begin
    if (!rst_n)
      O_RESOLVER_IRQ <= 1'b0;
    else
      O_RESOLVER_IRQ <= system_pending_event && system_interrupt_mask[RESOLVER_EVENT_BIT];
  end

  assign O_EXCITATION_DRIVE = excitation_drive_setting;

  // both channels share one scaler design; modes are independent
  assign chan_mode[0] = primary_channel_mode;
  assign chan_mode[1] = secondary_channel_mode;
  assign chan_angle[0] = I_PRI_ANGLE;
  assign chan_angle[1] = I_SEC_ANGLE;

  generate
    for (genvar ch = 0; ch < 2; ch++)
    begin : g_chan
      position_scaler u_scaler (
        .clk(I_CLK),
        .rst_n(rst_n),
        .mode(chan_mode[ch]),
        .angle(chan_angle[ch]),
        .position(chan_position[ch])
      );
    end
  endgenerate

  assign O_PRI_POSITION = chan_position[0];
  assign O_SEC_POSITION = chan_position[1];

  always_comb
  begin
    next_rdata = 32'h0000_0000;
    unique case (I_ADDR)
      OFS_PRI_MODE: next_rdata[MODE_W-1:0] = primary_channel_mode;
      OFS_SEC_MODE: next_rdata[MODE_W-1:0] = secondary_channel_mode;
      OFS_NOMINAL: next_rdata[AMP_W-1:0] = nominal_amplitude_target;
      OFS_DEADBAND: next_rdata[AMP_W-1:0] = amplitude_deadband;
      OFS_PRI_LOW_LIMIT: next_rdata[AMP_W-1:0] = primary_amplitude_low_limit;
      OFS_SEC_LOW_LIMIT: next_rdata[AMP_W-1:0] = secondary_amplitude_low_limit;
      OFS_PRI_ERROR: next_rdata[7:0] = primary_error_reason;
      OFS_SEC_ERROR: next_rdata[7:0] = secondary_error_reason;
      OFS_DRIVE: next_rdata[DRIVE_W-1:0] = excitation_drive_setting;
      OFS_CHECK_INTERVAL: next_rdata = amplitude_check_interval;
      OFS_IRQ_MASK: next_rdata[7:0] = system_interrupt_mask;
      OFS_PENDING: next_rdata[RESOLVER_EVENT_BIT] = system_pending_event;
      OFS_PRI_POSITION: next_rdata[POS_W-1:0] = chan_position[0];
      OFS_SEC_POSITION: next_rdata[POS_W-1:0] = chan_position[1];
      OFS_AMPLITUDES: next_rdata = {I_SEC_AMPLITUDE, I_PRI_AMPLITUDE};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // read data stand for one cycle after the strobe, zero otherwise
  always_ff @(posedge I_CLK or negedge rst_n)
  begin
    if (!rst_n)
      O_RDATA <= 32'h0000_0000;
    else if (I_RD)
      O_RDATA <= next_rdata;
    else
      O_RDATA <= 32'h0000_0000;
  end

endmodule

/* verification/resolver_sensor_model.sv */
`timescale 1ns/1ps
module resolver_sensor_model
(
  input wire logic i_clk,
  input wire logic [15:0] i_drive,
  input wire logic [15:0] i_pri_level,
  input wire logic [15:0] i_sec_level,
  input wire logic [15:0] i_speed,
  output logic [15:0] o_pri_amp = 16'h3A98,
  output logic [15:0] o_sec_amp = 16'h3A98,
  output logic [15:0] o_pri_angle = 16'h0000,
  output logic [15:0] o_sec_angle = 16'h0000
);
  // shared excitation: every drive unit above mid scale costs one amplitude unit
  always_ff @(posedge i_clk)
  begin
    o_pri_amp <= i_pri_level + 16'h8000 - i_drive;
    o_sec_amp <= i_sec_level + 16'h8000 - i_drive;
  end
  // secondary turns twice as fast so the two channels never match by accident
  always_ff @(posedge i_clk)
  begin
    o_pri_angle <= o_pri_angle + i_speed;
    o_sec_angle <= o_sec_angle + {i_speed[14:0], 1'b0};
  end
endmodule

/* verification/resolver_mode_supervision_assertions.sv */
`timescale 1ns/1ps
module resolver_mode_supervision_assertions
  import resolver_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_RSTN,
  input wire logic [7:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [POS_W-1:0] I_PRI_ANGLE,
  input wire logic [POS_W-1:0] I_SEC_ANGLE,
  input wire logic [31:0] O_RDATA,
  input wire logic [DRIVE_W-1:0] O_EXCITATION_DRIVE,
  input wire logic O_RESOLVER_IRQ,
  input wire logic [POS_W-1:0] O_PRI_POSITION,
  input wire logic [POS_W-1:0] O_SEC_POSITION
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RSTN);
  logic [8:0] pm;
  logic [8:0] sm;
  logic mask7;
  wire dwr = I_WR && I_ADDR == OFS_DRIVE;
  // decoded shadow flags, so that each $past below looks at one plain signal
  wire comp = pm[5];
  wire pri_hr = pm[3:0] != 4'h0 && pm[4] && !pm[7];
  wire pri_lr = pm[3:0] != 4'h0 && !pm[4] && !pm[7];
  wire pri_ccw = pm[3:0] != 4'h0 && pm[4] && pm[7];
  wire sec_hr = sm[3:0] != 4'h0 && sm[4] && !sm[7];
  // shadow of the mode and mask registers, rebuilt from bus writes
  always_ff @(posedge I_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      pm <= 9'h000;
      sm <= 9'h000;
      mask7 <= 1'b0;
    end
    else if (I_WR)
    begin
      if (I_ADDR == OFS_PRI_MODE) pm <= I_WDATA[8:0];
      if (I_ADDR == OFS_SEC_MODE) sm <= I_WDATA[8:0];
      if (I_ADDR == OFS_IRQ_MASK) mask7 <= I_WDATA[7];
    end
  end
  sequence s_mode_rd;
    I_RD && I_ADDR == OFS_PRI_MODE;
  endsequence
  sequence s_mode_back;
    O_RDATA[8:0] == $past(pm) && O_RDATA[31:9] == 23'h000000;
  endsequence
  a_mode_read_back: assert property (s_mode_rd |=> s_mode_back) else $error("mode read back wrong");
  a_pend_only_bit: assert property (I_RD && I_ADDR == OFS_PENDING |=> (O_RDATA & ~32'h80) == 32'h0)
    else $error("pending read has stray bits");
  a_irq_needs_mask: assert property (O_RESOLVER_IRQ |-> $past(mask7)) else $error("irq without mask");
  a_drive_unit_step: assert property ($changed(O_EXCITATION_DRIVE) && !$past(dwr) |->
    (O_EXCITATION_DRIVE - $past(O_EXCITATION_DRIVE)) inside {16'h0001, 16'hFFFF})
    else $error("drive moved by more than one");
  a_drive_hold_off: assert property (!$past(comp) && !$past(dwr) |-> $stable(O_EXCITATION_DRIVE))
    else $error("drive moved without compensation");
  a_pos_high_res: assert property ($past(pri_hr) |-> O_PRI_POSITION == $past(I_PRI_ANGLE))
    else $error("high resolution position wrong");
  a_pos_low_res: assert property ($past(pri_lr) |-> O_PRI_POSITION == ($past(I_PRI_ANGLE) >> 3))
    else $error("low resolution position wrong");
  a_pos_ccw_dir: assert property ($past(pri_ccw) |-> O_PRI_POSITION == 16'h0000 - $past(I_PRI_ANGLE))
    else $error("ccw position wrong");
  a_sec_high_res: assert property ($past(sec_hr) |-> O_SEC_POSITION == $past(I_SEC_ANGLE))
    else $error("secondary position wrong");
endmodule
bind resolver_mode_supervision resolver_mode_supervision_assertions resolver_mode_supervision_assertions_i (
  .I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD),
  .I_PRI_ANGLE(I_PRI_ANGLE), .I_SEC_ANGLE(I_SEC_ANGLE), .O_RDATA(O_RDATA), .O_EXCITATION_DRIVE(O_EXCITATION_DRIVE),
  .O_RESOLVER_IRQ(O_RESOLVER_IRQ), .O_PRI_POSITION(O_PRI_POSITION), .O_SEC_POSITION(O_SEC_POSITION));

/* verification/resolver_mode_supervision_tb.sv */
`timescale 1ns/1ps
module resolver_mode_supervision_tb
  import resolver_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n, wr, rd, irq;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, d;
  logic [15:0] drive, pri_pos, sec_pos, pri_amp, sec_amp, pri_ang, sec_ang, pri_lvl, sec_lvl, speed;
  int bad_count = 0;
  int tests_run = 0;
  int seed, e;
  localparam int NOM = int'(NOMINAL_RESET);
  localparam int DB = int'(DEADBAND_RESET);
  localparam logic [39:0] RST_TAB [8] = '{{OFS_PRI_MODE, 32'h0}, {OFS_NOMINAL, 32'h3A98}, {OFS_DEADBAND, 32'h64},
    {OFS_DRIVE, 32'h8000}, {OFS_CHECK_INTERVAL, 32'h3E8}, {OFS_IRQ_MASK, 32'h0}, {OFS_PENDING, 32'h0}, {8'h3C, 32'h0}};
  localparam logic [8:0] PM [4] = '{9'h001, 9'h011, 9'h081, 9'h091};
  localparam logic [15:0] LV [2] = '{16'h3B60, 16'h396C};
  localparam logic [39:0] FT [3] = '{{DRIVE_RESET, 16'h0032, REASON_LOW_AMPLITUDE},
    {DRIVE_MAX, 16'hBC8B, REASON_DRIVE_AT_MAX}, {DRIVE_MIN, 16'hB8A4, REASON_DRIVE_AT_MIN}};
  localparam int SPM [3] = '{17, 1, 17};
  localparam int SSM [3] = '{0, 1, 1};
  always #2 clk = ~clk;
  resolver_mode_supervision resolver_mode_supervision_i (.I_CLK(clk), .I_RSTN(rst_n), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .I_PRI_AMPLITUDE(pri_amp), .I_SEC_AMPLITUDE(sec_amp),
    .I_PRI_ANGLE(pri_ang), .I_SEC_ANGLE(sec_ang), .O_RDATA(rdata), .O_EXCITATION_DRIVE(drive),
    .O_RESOLVER_IRQ(irq), .O_PRI_POSITION(pri_pos), .O_SEC_POSITION(sec_pos));
  resolver_sensor_model resolver_sensor_model_i (.i_clk(clk), .i_drive(drive), .i_pri_level(pri_lvl),
    .i_sec_level(sec_lvl), .i_speed(speed), .o_pri_amp(pri_amp), .o_sec_amp(sec_amp),
    .o_pri_angle(pri_ang), .o_sec_angle(sec_ang));
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want)
    begin
      bad_count++;
      $display("unexpected at %0t: seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  function automatic logic [15:0] pos(input logic [8:0] m, input logic [15:0] a);
    logic [15:0] p;
    p = m[4] ? a : a >> 3;
    return m[7] ? 16'h0000 - p : p;
  endfunction
  // one unit per tick toward nominal until inside the deadband
  function automatic int settle(input int lvl, input int drv);
    int a;
    forever
    begin
      a = (lvl + 32'h8000 - drv) & 32'hFFFF;
      if (a - NOM > DB) drv++;
      else if (NOM - a > DB) drv--;
      else return drv;
    end
  endfunction
  initial
  begin
    #100000;
    bad_count++;
    report_and_stop;
  end
  initial
  begin
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    rst_n = 1'b0;
    pri_lvl = NOMINAL_RESET;
    sec_lvl = NOMINAL_RESET;
    speed = 16'h0000;
    seed = $urandom(32'h9723);
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    foreach (RST_TAB[k])
    begin
      rd_reg(RST_TAB[k][39:32], d);
      chk(d, RST_TAB[k][31:0]);
    end
    speed <= 16'($urandom);
    repeat (20) @(posedge clk);
    speed <= 16'h0000;
    foreach (PM[k])
    begin
      wr_reg(OFS_PRI_MODE, 32'(PM[k]));
      wr_reg(OFS_SEC_MODE, 32'(PM[k] ^ 9'h010));
      repeat (3) @(posedge clk);
      #1 chk(pri_pos, pos(PM[k], pri_ang));
      chk(sec_pos, pos(PM[k] ^ 9'h010, sec_ang));
      rd_reg(OFS_PRI_MODE, d);
      chk(d, 32'(PM[k]));
      rd_reg(OFS_SEC_POSITION, d);
      chk(d, 32'(pos(PM[k] ^ 9'h010, sec_ang)));
    end
    wr_reg(OFS_PRI_MODE, 32'd1);
    wr_reg(OFS_CHECK_INTERVAL, 32'd2);
    wr_reg(OFS_PENDING, 32'h80);
    e = 32'h8000;
    foreach (LV[k])
    begin
      pri_lvl <= LV[k];
      wr_reg(OFS_PRI_MODE, 32'd33);
      repeat (1200) @(posedge clk);
      e = settle(int'(LV[k]), e);
      chk(drive, e);
    end
    wr_reg(OFS_PRI_LOW_LIMIT, 32'd100);
    foreach (FT[k])
    begin
      wr_reg(OFS_PRI_MODE, 32'h0000_0001);
      wr_reg(OFS_DRIVE, 32'(FT[k][39:24]));
      pri_lvl <= FT[k][23:8];
      wr_reg(OFS_IRQ_MASK, k == 0 ? 32'h0 : 32'h80);
      wr_reg(OFS_PENDING, 32'h80);
      wr_reg(OFS_PRI_MODE, 32'd33);
      repeat (20) @(posedge clk);
      #1 chk(irq, k != 0);
      chk(drive, FT[k][39:24]);
      rd_reg(OFS_PRI_ERROR, d);
      chk(d, FT[k][7:0]);
      rd_reg(OFS_PENDING, d);
      chk(d, 32'h80);
    end
    wr_reg(OFS_PRI_MODE, 32'd1);
    wr_reg(OFS_PENDING, 32'h80);
    repeat (3) @(posedge clk);
    #1 chk(irq, 1'b0);
    pri_lvl <= NOMINAL_RESET;
    sec_lvl <= 16'h0032;
    wr_reg(OFS_DRIVE, 32'h8000);
    wr_reg(OFS_SEC_LOW_LIMIT, 32'd100);
    foreach (SPM[k])
    begin
      wr_reg(OFS_PENDING, 32'h80);
      wr_reg(OFS_PRI_MODE, SPM[k]);
      wr_reg(OFS_SEC_MODE, SSM[k]);
      repeat (10) @(posedge clk);
      rd_reg(OFS_SEC_ERROR, d);
      chk(d, k == 2 ? 32'h1 : 32'h0);
      rd_reg(OFS_PENDING, d);
      chk(d, k == 2 ? 32'h80 : 32'h0);
    end
    report_and_stop;
  end
endmodule
